// ===== hdl/ep_pkg.sv
// Shared constants, types and helpers for the energy pulse output timing block.
// Assumes a single 40 MHz core clock drives all of the logic.
package ep_pkg;

  localparam longint CLK_HZ = 40000000;
  localparam int CNT_W = 23;
  localparam int DIV_W = 16;
  localparam int IDLE_W = 8;

  // Pulse timing figures, in their own units
  localparam longint LF_WIDTH_MS = 120;
  localparam longint CF_WIDTH_MS = 90;
  localparam longint CF_HF_WIDTH_US = 35;
  localparam longint LF_GAP_US = 2;

  // Derived cycle counts: widths to the nearest cycle, the gap rounded up
  localparam logic [CNT_W-1:0] LF_WIDTH_CYC = CNT_W'((LF_WIDTH_MS * CLK_HZ + 500) / 1000);
  localparam logic [CNT_W-1:0] CF_WIDTH_CYC = CNT_W'((CF_WIDTH_MS * CLK_HZ + 500) / 1000);
  localparam logic [CNT_W-1:0] CF_HF_CYC = CNT_W'((CF_HF_WIDTH_US * CLK_HZ + 500000) / 1000000);
  localparam logic [CNT_W-1:0] LF_GAP_CYC = CNT_W'((LF_GAP_US * CLK_HZ + 999999) / 1000000);

  // Energy ticks per low-frequency output period, one per conversion select code
  localparam logic [DIV_W-1:0] LF_DIV_0 = 16'h0010;
  localparam logic [DIV_W-1:0] LF_DIV_1 = 16'h0020;
  localparam logic [DIV_W-1:0] LF_DIV_2 = 16'h0040;
  localparam logic [DIV_W-1:0] LF_DIV_3 = 16'h0080;
  // Energy ticks per calibration pulse, normal and high-frequency rate
  localparam logic [DIV_W-1:0] CF_DIV_NORM = 16'h0004;
  localparam logic [DIV_W-1:0] CF_DIV_HF = 16'h0001;

  localparam logic [CNT_W-1:0] CNT_ONE = 23'h000001;
  localparam logic [CNT_W-1:0] CNT_MAX = 23'h7FFFFF;
  localparam logic [DIV_W-1:0] DIV_ONE = 16'h0001;

  typedef enum logic [0:0] {
    LF_IDLE = 1'b0,
    LF_WAIT = 1'b1
  } ep_lf_state_t;

  // Nominal width, cut back so the pulse ends gap cycles before the next one
  function automatic logic [CNT_W-1:0] ep_fit_width(input logic [CNT_W-1:0] nom,
                                                    input logic [CNT_W-1:0] ival,
                                                    input logic [CNT_W-1:0] gap);
    logic [CNT_W-1:0] room;
    room = (ival > gap) ? CNT_W'(ival - gap) : CNT_ONE;
    if (room == '0) begin
      room = CNT_ONE;
    end
    return (room < nom) ? room : nom;
  endfunction : ep_fit_width

endpackage : ep_pkg

// ===== hdl/ep_pulse_gen.sv
// One-shot pulse generator driving a single output pin.
// Assumes start and stop come from logic on the same clock, never together.
`timescale 1ns/1ps
`default_nettype none
module ep_pulse_gen
  import ep_pkg::*;
#(
  parameter logic IDLE_LVL = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic [CNT_W-1:0] width_i,
  output logic active_o,
  output logic pin_o
);

  logic act_ff;
  logic pin_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic nxt_act;
  logic [CNT_W-1:0] nxt_cnt;
  wire last_cycle = act_ff && (cnt_ff <= CNT_ONE);

  // A restart while active begins a fresh full-width pulse
  assign nxt_act = start_i ? 1'b1 : (stop_i || last_cycle) ? 1'b0 : act_ff;
  assign nxt_cnt = start_i ? width_i : (act_ff && cnt_ff != '0) ? CNT_W'(cnt_ff - CNT_ONE) : cnt_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_ff <= 1'b0;
      pin_ff <= IDLE_LVL;
      cnt_ff <= '0;
    end else begin
      act_ff <= nxt_act;
      pin_ff <= nxt_act ? ~IDLE_LVL : IDLE_LVL;
      cnt_ff <= nxt_cnt;
    end
  end

  assign active_o = act_ff;
  assign pin_o = pin_ff;

  a_width_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (act_ff && !stop_i && cnt_ff > CNT_ONE) |=> act_ff)
    else $error("pulse ended before its width ran out");

  a_pin_follows: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pin_ff == (act_ff ? ~IDLE_LVL : IDLE_LVL))
    else $error("pin level disagrees with pulse state");

endmodule : ep_pulse_gen
`default_nettype wire

// ===== hdl/ep_pulse_timing.sv
// Energy pulse output timing: shapes energy-rate ticks into two alternating
// low-frequency drive pulses, a calibration pulse and a negative power flag.
// Assumes energy ticks and the power sign come from the core clock domain and
// the select pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module ep_pulse_timing
  import ep_pkg::*;
#(
  parameter logic [CNT_W-1:0] LF_WIDTH = LF_WIDTH_CYC,
  parameter logic [CNT_W-1:0] CF_WIDTH = CF_WIDTH_CYC
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic energy_tick_i,
  input wire logic neg_power_i,
  input wire logic conv_freq_sel_lo_i,
  input wire logic conv_freq_sel_hi_i,
  input wire logic calib_rate_sel_i,
  output logic energy_pulse_a_o,
  output logic energy_pulse_b_o,
  output logic calibration_pulse_out_o,
  output logic negative_power_flag_o
);

  logic rst_s1_ff;
  logic rst_n_ff;
  logic [2:0] sel_s1_ff;
  logic [2:0] sel_s2_ff;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff <= rst_s1_ff;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sel_s1_ff <= 3'h0;
      sel_s2_ff <= 3'h0;
    end else begin
      sel_s1_ff <= {calib_rate_sel_i, conv_freq_sel_hi_i, conv_freq_sel_lo_i};
      sel_s2_ff <= sel_s1_ff;
    end
  end

  wire [1:0] conv_sel = sel_s2_ff[1:0];
  wire hf_mode = sel_s2_ff[2];

  // Rate selection
  wire [DIV_W-1:0] lf_div = (conv_sel == 2'h0) ? LF_DIV_0 :
                            (conv_sel == 2'h1) ? LF_DIV_1 :
                            (conv_sel == 2'h2) ? LF_DIV_2 : LF_DIV_3;
  wire [DIV_W-1:0] lf_half_raw = lf_div >> 1;
  wire [DIV_W-1:0] lf_half = (lf_half_raw == '0) ? DIV_ONE : lf_half_raw;
  wire [DIV_W-1:0] cf_div = hf_mode ? CF_DIV_HF : CF_DIV_NORM;

  logic [DIV_W-1:0] lf_tick_ff;
  logic [DIV_W-1:0] cf_tick_ff;
  wire [DIV_W-1:0] lf_tick_inc = DIV_W'(lf_tick_ff + DIV_ONE);
  wire [DIV_W-1:0] cf_tick_inc = DIV_W'(cf_tick_ff + DIV_ONE);
  // A select change mid-count applies from the next tick; a count already past the new half wraps on that tick
  wire half_evt = energy_tick_i && (lf_tick_inc >= lf_half);
  wire cf_evt = energy_tick_i && (cf_tick_inc >= cf_div);

  always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      lf_tick_ff <= '0;
      cf_tick_ff <= '0;
    end else begin
      if (energy_tick_i) begin
        lf_tick_ff <= half_evt ? '0 : lf_tick_inc;
        cf_tick_ff <= cf_evt ? '0 : cf_tick_inc;
      end
    end
  end

  // Spacing between output events, measured to cut widths at high rates
  logic [CNT_W-1:0] lf_ival_ff;
  logic [CNT_W-1:0] cf_ival_ff;
  wire [CNT_W-1:0] lf_ival_inc = (lf_ival_ff == CNT_MAX) ? CNT_MAX : CNT_W'(lf_ival_ff + CNT_ONE);
  wire [CNT_W-1:0] cf_ival_inc = (cf_ival_ff == CNT_MAX) ? CNT_MAX : CNT_W'(cf_ival_ff + CNT_ONE);

  always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      lf_ival_ff <= CNT_MAX;
      cf_ival_ff <= CNT_MAX;
    end else begin
      lf_ival_ff <= half_evt ? CNT_ONE : lf_ival_inc;
      cf_ival_ff <= cf_evt ? CNT_ONE : cf_ival_inc;
    end
  end

  wire [CNT_W-1:0] lf_width_now = ep_fit_width(LF_WIDTH, lf_ival_ff, LF_GAP_CYC);
  wire [CNT_W-1:0] cf_width_now = hf_mode ? CF_HF_CYC :
                                  ep_fit_width(CF_WIDTH, cf_ival_ff >> 1, '0);

  // Low-frequency alternation; phase 0 starts output a, phase 1 output b
  ep_lf_state_t lf_state_ff;
  ep_lf_state_t nxt_lf_state;
  logic phase_ff;
  logic side_ff;
  logic [CNT_W-1:0] hold_width_ff;
  logic [IDLE_W-1:0] quiet_ff;
  logic a_act;
  logic b_act;
  logic cf_act;

  // Quiet once both outputs have stood idle for the gap, this cycle included
  wire lf_quiet = !a_act && !b_act && (quiet_ff >= LF_GAP_CYC - CNT_ONE);
  wire lf_req = half_evt || (lf_state_ff == LF_WAIT);
  wire req_side = half_evt ? phase_ff : side_ff;
  wire lf_go = lf_req && lf_quiet;
  // Cutting a running pulse and waiting out the gap keeps the outputs apart;
  // a later event during the wait replaces the pending start
  wire stop_a = half_evt && a_act;
  wire stop_b = half_evt && b_act;
  wire start_a = lf_go && !req_side;
  wire start_b = lf_go && req_side;
  wire [CNT_W-1:0] lf_width_sel = half_evt ? lf_width_now : hold_width_ff;

  always_comb begin
    nxt_lf_state = lf_state_ff;
    case (lf_state_ff)
      LF_IDLE: begin
        if (half_evt && !lf_quiet) begin
          nxt_lf_state = LF_WAIT;
        end
      end
      LF_WAIT: begin
        if (lf_quiet) begin
          nxt_lf_state = LF_IDLE;
        end
      end
      default: begin
        nxt_lf_state = LF_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      lf_state_ff <= LF_IDLE;
      phase_ff <= 1'b0;
      side_ff <= 1'b0;
      hold_width_ff <= '0;
      quiet_ff <= '1;
    end else begin
      lf_state_ff <= nxt_lf_state;
      quiet_ff <= (a_act || b_act) ? '0 : (&quiet_ff) ? quiet_ff : IDLE_W'(quiet_ff + 1'b1);
      if (half_evt) begin
        phase_ff <= ~phase_ff;
        side_ff <= phase_ff;
        hold_width_ff <= lf_width_now;
      end
    end
  end

  // Sign is sampled only as a calibration pulse starts and held until the next one
  logic neg_flag_ff;
  always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      neg_flag_ff <= 1'b0;
    end else if (cf_evt) begin
      neg_flag_ff <= neg_power_i;
    end
  end

  ep_pulse_gen #(.IDLE_LVL(1'b1)) u_pulse_a (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n_ff),
    .start_i(start_a),
    .stop_i(stop_a),
    .width_i(lf_width_sel),
    .active_o(a_act),
    .pin_o(energy_pulse_a_o)
  );

  ep_pulse_gen #(.IDLE_LVL(1'b1)) u_pulse_b (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n_ff),
    .start_i(start_b),
    .stop_i(stop_b),
    .width_i(lf_width_sel),
    .active_o(b_act),
    .pin_o(energy_pulse_b_o)
  );

  ep_pulse_gen #(.IDLE_LVL(1'b0)) u_pulse_cf (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n_ff),
    .start_i(cf_evt),
    .stop_i(1'b0),
    .width_i(cf_width_now),
    .active_o(cf_act),
    .pin_o(calibration_pulse_out_o)
  );

  assign negative_power_flag_o = neg_flag_ff;

  // Helper counters watched only by the checks below
  logic [IDLE_W-1:0] idle_cnt_ff;
  logic [CNT_W-1:0] a_len_ff;
  logic [CNT_W-1:0] cf_len_ff;
  logic cf_hf_ff;
  always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      idle_cnt_ff <= '1;
      a_len_ff <= '0;
      cf_len_ff <= '0;
      cf_hf_ff <= 1'b0;
    end else begin
      idle_cnt_ff <= (a_act || b_act) ? '0 : (&idle_cnt_ff) ? idle_cnt_ff : IDLE_W'(idle_cnt_ff + 1'b1);
      a_len_ff <= start_a ? '0 : a_act ? CNT_W'(a_len_ff + CNT_ONE) : a_len_ff;
      cf_len_ff <= cf_evt ? '0 : cf_act ? CNT_W'(cf_len_ff + CNT_ONE) : cf_len_ff;
      if (cf_evt) begin
        cf_hf_ff <= hf_mode;
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_ff);

  sequence s_cf_issue;
    cf_evt ##1 cf_act;
  endsequence

  sequence s_lf_cut;
    half_evt && (a_act || b_act);
  endsequence

  a_lf_cut_off: assert property (s_lf_cut |=> !a_act && !b_act)
    else $error("running low-frequency pulse not cut at a new event");

  a_lf_no_overlap: assert property (!(a_act && b_act))
    else $error("both low-frequency outputs active together");

  a_lf_gap_kept: assert property (($rose(a_act) || $rose(b_act)) |-> idle_cnt_ff >= LF_GAP_CYC)
    else $error("low-frequency pulses closer than the minimum gap");

  a_lf_width_cap: assert property ($fell(a_act) && !$past(stop_a) |-> a_len_ff <= LF_WIDTH && a_len_ff != '0)
    else $error("low-frequency pulse longer than nominal");

  a_lf_alternate: assert property (lf_go |-> (start_a != start_b))
    else $error("low-frequency outputs did not alternate");

  a_cf_hf_width: assert property ($fell(cf_act) && cf_hf_ff |-> cf_len_ff == CF_HF_CYC)
    else $error("high-frequency calibration pulse not exact width");

  a_cf_norm_cap: assert property ($fell(cf_act) && !cf_hf_ff |-> cf_len_ff <= CF_WIDTH)
    else $error("calibration pulse longer than nominal");

  a_flag_at_cf: assert property ($changed(neg_flag_ff) |-> $past(cf_evt))
    else $error("negative flag moved without a calibration pulse");

  a_flag_value: assert property (s_cf_issue |-> neg_flag_ff == $past(neg_power_i))
    else $error("negative flag does not follow power sign");

  a_half_on_tick: assert property (half_evt |-> energy_tick_i && lf_tick_inc >= lf_half)
    else $error("output event without an energy tick");

endmodule : ep_pulse_timing
`default_nettype wire

// ===== bench/ep_meter_model.sv
// Far-side meter model: watches the two drive pulses and the calibration pulse
// and reports widths, the fall-to-fall distance and the smallest idle gap.
// Assumes the outputs are sampled on the core clock; one cycle is the unit.
`timescale 1ns/1ps
`default_nettype none
module ep_meter_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pulse_a_i,
  input wire logic pulse_b_i,
  input wire logic cal_i,
  output logic [31:0] a_w_o,
  output logic [31:0] b_w_o,
  output logic [31:0] cf_w_o,
  output logic [31:0] sep_o,
  output logic [31:0] gap_min_o,
  output logic [31:0] a_falls_o
);
  logic [31:0] cyc_ff, a_fall_ff, b_fall_ff, a_rise_ff, b_rise_ff, cf_rise_ff;
  logic a_d_ff, b_d_ff, cf_d_ff;
  // An overlap counts as a zero gap, so a fall under a live pulse is caught
  wire [31:0] gap_a = pulse_b_i ? (cyc_ff - b_rise_ff) : 32'h0;
  wire [31:0] gap_b = pulse_a_i ? (cyc_ff - a_rise_ff) : 32'h0;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {cyc_ff, a_fall_ff, b_fall_ff, a_rise_ff, b_rise_ff, cf_rise_ff} <= '0;
      {a_w_o, b_w_o, cf_w_o, sep_o, a_falls_o} <= '0;
      gap_min_o <= 32'hFFFFFFFF;
      {a_d_ff, b_d_ff, cf_d_ff} <= 3'h6;
    end else begin
      cyc_ff <= cyc_ff + 1;
      a_d_ff <= pulse_a_i;
      b_d_ff <= pulse_b_i;
      cf_d_ff <= cal_i;
      if (a_d_ff && !pulse_a_i) begin
        a_fall_ff <= cyc_ff;
        a_falls_o <= a_falls_o + 1;
        if (gap_a < gap_min_o) gap_min_o <= gap_a;
      end
      if (b_d_ff && !pulse_b_i) begin
        b_fall_ff <= cyc_ff;
        sep_o <= cyc_ff - a_fall_ff;
        if (gap_b < gap_min_o) gap_min_o <= gap_b;
      end
      if (!a_d_ff && pulse_a_i) begin
        a_rise_ff <= cyc_ff;
        a_w_o <= cyc_ff - a_fall_ff;
      end
      if (!b_d_ff && pulse_b_i) begin
        b_rise_ff <= cyc_ff;
        b_w_o <= cyc_ff - b_fall_ff;
      end
      if (!cf_d_ff && cal_i) cf_rise_ff <= cyc_ff;
      if (cf_d_ff && !cal_i) cf_w_o <= cyc_ff - cf_rise_ff;
    end
  end
endmodule : ep_meter_model
`default_nettype wire

// ===== bench/ep_pulse_timing_test.sv
// Testbench for the energy pulse output timing block with short pulse widths.
// Assumes the meter model measures everything in core clock cycles.
`timescale 1ns/1ps
`default_nettype none
module ep_pulse_timing_test;
  import ep_pkg::*;
  localparam logic [CNT_W-1:0] T_LF = 23'h0000C8;
  localparam logic [CNT_W-1:0] T_CF = 23'h000096;
  logic clk, nrst, tick, neg, sel_lo, sel_hi, rate;
  wire pa, pb, cf, flag;
  wire [31:0] a_w, b_w, cf_w, sep, gap_min, a_falls;
  int n_mismatch = 0;
  int total_checks = 0;

  ep_pulse_timing #(.LF_WIDTH(T_LF), .CF_WIDTH(T_CF)) i_dut (.core_clk_i(clk), .nrst_i(nrst),
    .energy_tick_i(tick), .neg_power_i(neg), .conv_freq_sel_lo_i(sel_lo),
    .conv_freq_sel_hi_i(sel_hi), .calib_rate_sel_i(rate), .energy_pulse_a_o(pa),
    .energy_pulse_b_o(pb), .calibration_pulse_out_o(cf), .negative_power_flag_o(flag));
  ep_meter_model i_meter (.clk_i(clk), .rst_n_i(nrst), .pulse_a_i(pa), .pulse_b_i(pb),
    .cal_i(cf), .a_w_o(a_w), .b_w_o(b_w), .cf_w_o(cf_w), .sep_o(sep), .gap_min_o(gap_min),
    .a_falls_o(a_falls));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %0d, seen %0d", name, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic do_reset();
    @(negedge clk) nrst = 1'b0;
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
  endtask : do_reset

  // One-cycle energy ticks, spaced gap cycles apart
  task automatic ticks(input int n, input int gap);
    repeat (n) begin
      @(negedge clk) tick = 1'b1;
      @(negedge clk) tick = 1'b0;
      repeat (gap - 2) @(negedge clk);
    end
  endtask : ticks

  task automatic t_reset();
    nrst = 1'b0;
    repeat (3) @(negedge clk);
    check("pulse a idle", pa, 1);
    check("pulse b idle", pb, 1);
    check("cal idle", cf, 0);
    check("flag idle", flag, 0);
  endtask : t_reset

  task automatic t_normal();
    {sel_hi, sel_lo, rate, neg} = 4'h1;
    do_reset();
    ticks(4, 300);
    check("cal width", cf_w, 150);
    check("flag neg", flag, 1);
    ticks(12, 50);
    repeat (300) @(negedge clk);
    check("a width", a_w, 200);
    check("b width", b_w, 200);
    check("fall separation", sep, 400);
    check("cal shortened", cf_w, 100);
    ticks(16, 30);
    repeat (300) @(negedge clk);
    check("a full width", a_w, 200);
    check("b shortened", b_w, 160);
    check("deferred separation", sep, 280);
    neg = 1'b0;
    ticks(32, 2);
    repeat (400) @(negedge clk);
    check("min gap ok", gap_min >= 80, 1);
    check("flag positive", flag, 0);
  endtask : t_normal

  task automatic t_select();
    int n;
    for (int code = 0; code < 4; code++) begin
      {sel_hi, sel_lo} = code[1:0];
      rate = 1'b0;
      do_reset();
      n = 0;
      while (a_falls == 0 && n < 200) begin
        ticks(1, 10);
        n++;
      end
      check("ticks to first a", n, 8 << code);
    end
  endtask : t_select

  task automatic t_high_freq();
    rate = 1'b1;
    neg = 1'b1;
    do_reset();
    ticks(2, 2000);
    check("hf cal width", cf_w, 1400);
    check("hf flag", flag, 1);
  endtask : t_high_freq

  initial begin
    {nrst, tick, neg, sel_lo, sel_hi, rate} = '0;
    repeat (10) @(negedge clk);
    t_reset();
    t_normal();
    t_select();
    t_high_freq();
    give_verdict();
  end

  // Whole run needs about 8650 cycles
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
endmodule : ep_pulse_timing_test
`default_nettype wire
